// File: shared/correlator_defs.vh
// constants for the binary correlator block: register map, fields, resets
// assumes a plain register port with one-cycle read latency
//
// Contract
// RL1: array is eight stages of 32 taps, chained for 1/2/4/8-bit data
// RL2: window scales with precision, 8x32 down to 1x256
// RL3: split mode gives two correlators, 4x32 down to 1x128 each
// RL4: one mask bit per tap; set bit removes that tap from score
// RL5: agreements pass weight-and-sum with host-chosen weight per bit position; only positions 0-3 are writable, 4-7 stay at shift 0
// RL6: host offset is added to every weighted score
// RL7: score passes programmable delay into cascade summer
// RL8: host configures through control registers over processor bus
// RL9: control, mask, reference double buffered; active copy stays undisturbed
// RL10: one-dimensional and two-dimensional correlation both supported
// RL11: buffered contents move to active copies only on host transfer
`ifndef CORRELATOR_DEFS_VH
`define CORRELATOR_DEFS_VH

`define ADR_W          6
`define ADR_CTRL       6'h00
`define ADR_WEIGHT     6'h01
`define ADR_OFFSET     6'h02
`define ADR_DELAY      6'h03
`define ADR_XFER       6'h04
`define ADR_STATUS     6'h05
`define ADR_SCORE_A    6'h06
`define ADR_SCORE_B    6'h07
`define ADR_MASK0      6'h10
`define ADR_REF0       6'h20
`define ADR_BANK_MSK   6'h30
`define ADR_IDX_MSK    6'h0f

`define CTRL_PREC_LO   0
`define CTRL_PREC_HI   1
`define CTRL_SPLIT     2
`define PREC_1BIT      2'h0
`define PREC_2BIT      2'h1
`define PREC_4BIT      2'h2
`define PREC_8BIT      2'h3

`define CTRL_RST       3'h0
`define WEIGHT_RST     32'h0000_0000
`define OFFSET_RST     16'h0000
`define DELAY_RST      4'h0
`define WORD_RST       16'h0000

`endif

// File: hdl/corr_fifo.v
// synchronous fifo with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
module corr_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW    = 5
) (
   input  wire             clk,
   input  wire             arst_n,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @* begin
      out_data = mem[rd_q];
   end

   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

// File: hdl/corr_delay.v
// programmable delay line for the offset score
// assumes one clock; tap 0 means no extra delay
`timescale 1ns/1ps
module corr_delay #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter SW    = 4
) (
   input  wire             clk,
   input  wire             arst_n,
   input  wire             shift,
   input  wire [SW-1:0]    sel,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] line_q [0:DEPTH-1];
   integer i;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            line_q[i] <= {WIDTH{1'b0}};
         end
      end else if (shift) begin
         line_q[0] <= din;
         for (i = 1; i < DEPTH; i = i + 1) begin
            line_q[i] <= line_q[i-1];
         end
      end
   end

   always @* begin
      dout = (sel == {SW{1'b0}}) ? din : line_q[sel - 1'b1];
   end
endmodule

// File: hdl/binary_correlator.v
// binary correlator: 256 taps in eight 32-tap stages, 1-bit reference
// assumes register port with one-cycle read data, samples via valid/ready
`timescale 1ns/1ps
`include "correlator_defs.vh"
module binary_correlator #(
   parameter TAPS  = 256,
   parameter STAGE = 32,
   parameter DW    = 8,
   parameter SCW   = 16,
   parameter DLY   = 16
) (
   input  wire           clk,
   input  wire           arst_n,
   input  wire [5:0]     reg_addr,
   input  wire [15:0]    reg_wdata,
   input  wire           reg_wr,
   input  wire           reg_rd,
   output reg  [15:0]    reg_rdata,
   input  wire [DW-1:0]  samp_a,
   input  wire [DW-1:0]  samp_b,
   input  wire           samp_valid,
   output wire           samp_ready,
   input  wire [SCW-1:0] cascade_in,
   output wire [SCW-1:0] score_out,
   output wire           score_valid,
   input  wire           score_ready
);
   localparam NW = TAPS / 16;

   ////////////////////////////////////////////////////////////////////////
   // shadow and active registers
   reg  [2:0]      ctrl_sh_q;
   reg  [2:0]      ctrl_q;
   reg  [31:0]     wgt_sh_q;
   reg  [31:0]     wgt_q;
   reg  [15:0]     ofs_sh_q;
   reg  [15:0]     ofs_q;
   reg  [3:0]      dly_sh_q;
   reg  [3:0]      dly_q;
   reg  [TAPS-1:0] mask_sh_q;
   reg  [TAPS-1:0] mask_q;
   reg  [TAPS-1:0] ref_sh_q;
   reg  [TAPS-1:0] ref_q;
   reg  [15:0]     xfer_cnt_q;
   reg  [SCW-1:0]  last_a_q;
   reg  [SCW-1:0]  last_b_q;
   wire            xfer;
   wire [5:0]      idx;
   wire            hit_mask;
   wire            hit_ref;
   genvar          gw;

   // RL8 host bus writes
   assign xfer     = reg_wr & (reg_addr == `ADR_XFER);
   assign idx      = reg_addr & `ADR_IDX_MSK;
   assign hit_mask = reg_wr & ((reg_addr & `ADR_BANK_MSK) == `ADR_MASK0);
   assign hit_ref  = reg_wr & ((reg_addr & `ADR_BANK_MSK) == `ADR_REF0);

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_sh_q <= `CTRL_RST;
         wgt_sh_q  <= `WEIGHT_RST;
         ofs_sh_q  <= `OFFSET_RST;
         dly_sh_q  <= `DELAY_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            `ADR_CTRL:   ctrl_sh_q <= reg_wdata[2:0];
            `ADR_WEIGHT: wgt_sh_q  <= {16'h0000, reg_wdata};
            `ADR_OFFSET: ofs_sh_q  <= reg_wdata;
            `ADR_DELAY:  dly_sh_q  <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   // RL4 RL9 mask and reference words into shadows
   generate
      for (gw = 0; gw < NW; gw = gw + 1) begin : word
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               mask_sh_q[gw*16 +: 16] <= `WORD_RST;
               ref_sh_q[gw*16 +: 16]  <= `WORD_RST;
            end else begin
               if (hit_mask && idx == gw)
                  mask_sh_q[gw*16 +: 16] <= reg_wdata;
               if (hit_ref && idx == gw)
                  ref_sh_q[gw*16 +: 16]  <= reg_wdata;
            end
         end
      end
   endgenerate

   // RL9 RL11 active copies change only on transfer
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_q     <= `CTRL_RST;
         wgt_q      <= `WEIGHT_RST;
         ofs_q      <= `OFFSET_RST;
         dly_q      <= `DELAY_RST;
         mask_q     <= {TAPS{1'b0}};
         ref_q      <= {TAPS{1'b0}};
         xfer_cnt_q <= `WORD_RST;
      end else if (xfer) begin
         ctrl_q     <= ctrl_sh_q;
         wgt_q      <= wgt_sh_q;
         ofs_q      <= ofs_sh_q;
         dly_q      <= dly_sh_q;
         mask_q     <= mask_sh_q;
         ref_q      <= ref_sh_q;
         xfer_cnt_q <= xfer_cnt_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tap array
   wire [1:0]      prec  = ctrl_q[`CTRL_PREC_HI:`CTRL_PREC_LO];
   wire            split = ctrl_q[`CTRL_SPLIT];
   reg  [TAPS-1:0] shreg_q;
   reg  [TAPS-1:0] shnext;
   reg  [TAPS-1:0] agree;
   wire            fire;
   integer         r;
   integer         t;

   // RL1 RL2 RL3 RL10 rows chained by precision; split halves the array
   always @* begin
      shnext = shreg_q;
      for (r = 0; r < 8; r = r + 1) begin
         for (t = STAGE-1; t > 0; t = t - 1)
            shnext[r*STAGE+t] = shreg_q[r*STAGE+t-1];
         // row r head: own data bit, or chained from previous row
         case (prec)
            `PREC_8BIT: shnext[r*STAGE] = samp_a[r];
            `PREC_4BIT: shnext[r*STAGE] = (r % 2 == 0) ?
               (split && r >= 4 ? samp_b[(r-4)/2] : samp_a[r/2]) :
               shreg_q[r*STAGE-1];
            `PREC_2BIT: shnext[r*STAGE] = (r % 4 == 0) ?
               (split && r >= 4 ? samp_b[0] : samp_a[r/4]) :
               shreg_q[r*STAGE-1];
            default: shnext[r*STAGE] = (r == 0) ? samp_a[0] :
               (split && r == 4) ? samp_b[0] : shreg_q[r*STAGE-1];
         endcase
         if (split) begin
            case (prec)
               `PREC_4BIT: shnext[r*STAGE] = (r % 2 == 0) ?
                  (r >= 4 ? samp_b[(r-4)/2] : samp_a[r/2]) :
                  shreg_q[r*STAGE-1];
               `PREC_8BIT: shnext[r*STAGE] = (r >= 4) ?
                  samp_b[r-4] : samp_a[r];
               default: shnext[r*STAGE] = shnext[r*STAGE];
            endcase
         end
      end
   end

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         shreg_q <= {TAPS{1'b0}};
      else if (fire)
         shreg_q <= shnext;
   end

   // RL4 masked taps contribute nothing
   genvar g;
   generate
      for (g = 0; g < TAPS; g = g + 1) begin : tap
         always @* agree[g] = ~(shreg_q[g] ^ ref_q[g]) & ~mask_q[g];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // weight and sum
   reg [8*SCW-1:0] row_term;
   reg [SCW-1:0]   sum_a;
   reg [SCW-1:0]   sum_b;
   integer         rs;
   genvar          gr;

   // RL5 row count shifted by its bit position weight
   generate
      for (gr = 0; gr < 8; gr = gr + 1) begin : row
         reg [5:0] cnt;
         reg [3:0] w;
         integer   j;
         integer   p;
         always @* begin
            cnt = 6'h00;
            for (j = 0; j < STAGE; j = j + 1)
               cnt = cnt + {5'h00, agree[gr*STAGE+j]};
            case (prec)
               `PREC_8BIT: p = (split && gr >= 4) ? gr - 4 : gr;
               `PREC_4BIT: p = (split && gr >= 4) ? (gr - 4) / 2 : gr / 2;
               `PREC_2BIT: p = (split && gr >= 4) ? 0 : gr / 4;
               default:    p = 0;
            endcase
            w = wgt_q[p*4 +: 4];
            row_term[gr*SCW +: SCW] = {{(SCW-6){1'b0}}, cnt} << w;
         end
      end
   endgenerate

   // split: upper four rows form the second score
   always @* begin
      sum_a = {SCW{1'b0}};
      sum_b = {SCW{1'b0}};
      for (rs = 0; rs < 8; rs = rs + 1) begin
         if (split && rs >= 4)
            sum_b = sum_b + row_term[rs*SCW +: SCW];
         else
            sum_a = sum_a + row_term[rs*SCW +: SCW];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // offset, delay, cascade
   reg  [SCW-1:0] ofs_score_q;
   reg            ofs_vld_q;
   wire [SCW-1:0] dly_score;
   wire [SCW-1:0] casc_sum;
   wire           fifo_ready;
   wire           stage_free;
   wire           stage_push;
   wire [SCW-1:0] fifo_data;
   wire           fifo_valid;
   wire           fifo_take;
   wire           fifo_pop;
   reg  [SCW-1:0] score_q;
   reg            score_vld_q;

   // score stage holds its word while the fifo is full
   assign stage_push = ofs_vld_q & fifo_ready;
   assign stage_free = ~ofs_vld_q | fifo_ready;
   assign fire       = samp_valid & stage_free;
   assign samp_ready = stage_free;

   // RL6 offset added to every score
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ofs_score_q <= {SCW{1'b0}};
         ofs_vld_q   <= 1'b0;
         last_a_q    <= {SCW{1'b0}};
         last_b_q    <= {SCW{1'b0}};
      end else begin
         ofs_vld_q <= fire | (ofs_vld_q & ~fifo_ready);
         if (fire) begin
            ofs_score_q <= sum_a + ofs_q[SCW-1:0];
            last_a_q    <= sum_a + ofs_q[SCW-1:0];
            last_b_q    <= sum_b + ofs_q[SCW-1:0];
         end
      end
   end

   // RL7 programmable delay into cascade summer
   corr_delay #(.WIDTH(SCW), .DEPTH(DLY), .SW(4)) u_dly (
      .clk    (clk),
      .arst_n (arst_n),
      .shift  (stage_push),
      .sel    (dly_q),
      .din    (ofs_score_q),
      .dout   (dly_score)
   );

   assign casc_sum = dly_score + cascade_in;

   corr_fifo #(.WIDTH(SCW), .DEPTH(32), .AW(5)) u_fifo (
      .clk       (clk),
      .arst_n    (arst_n),
      .in_data   (casc_sum),
      .in_valid  (ofs_vld_q),
      .in_ready  (fifo_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_take)
   );

   // output register keeps score_out off the fifo read mux
   assign fifo_take   = ~score_vld_q | score_ready;
   assign fifo_pop    = fifo_valid & fifo_take;
   assign score_out   = score_q;
   assign score_valid = score_vld_q;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         score_q     <= {SCW{1'b0}};
         score_vld_q <= 1'b0;
      end else begin
         score_vld_q <= fifo_pop | (score_vld_q & ~score_ready);
         if (fifo_pop)
            score_q <= fifo_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n)
         reg_rdata <= `WORD_RST;
      else if (reg_rd) begin
         case (reg_addr)
            `ADR_CTRL:    reg_rdata <= {13'h0000, ctrl_q};
            `ADR_WEIGHT:  reg_rdata <= wgt_q[15:0];
            `ADR_OFFSET:  reg_rdata <= ofs_q;
            `ADR_DELAY:   reg_rdata <= {12'h000, dly_q};
            `ADR_STATUS:  reg_rdata <= xfer_cnt_q;
            `ADR_SCORE_A: reg_rdata <= last_a_q;
            `ADR_SCORE_B: reg_rdata <= last_b_q;
            default:      reg_rdata <= `WORD_RST;
         endcase
      end else
         reg_rdata <= `WORD_RST;
   end
endmodule

// File: sim/corr_checker_assertions.sv
// port checker for binary_correlator: register reads, score stream
// assumes bind to the correlator top, one clock, reset arst_n
`timescale 1ns/1ps
`include "correlator_defs.vh"
module corr_checker #(
   parameter DW  = 8,
   parameter SCW = 16
) (
   input wire           clk,
   input wire           arst_n,
   input wire [5:0]     reg_addr,
   input wire [15:0]    reg_wdata,
   input wire           reg_wr,
   input wire           reg_rd,
   input wire [15:0]    reg_rdata,
   input wire [DW-1:0]  samp_a,
   input wire [DW-1:0]  samp_b,
   input wire           samp_valid,
   input wire           samp_ready,
   input wire [SCW-1:0] cascade_in,
   input wire [SCW-1:0] score_out,
   input wire           score_valid,
   input wire           score_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   sequence s_off_xfer;
      reg_wr && reg_addr == `ADR_OFFSET ##2 reg_wr && reg_addr == `ADR_XFER
      ##2 reg_rd && reg_addr == `ADR_OFFSET;
   endsequence
   sequence s_xfer_stat;
      reg_wr && reg_addr == `ADR_XFER ##2 reg_rd && reg_addr == `ADR_STATUS;
   endsequence
   a_read_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata idle");
   a_unmapped_zero: assert property (
      reg_rd && reg_addr == 6'h08 |=> reg_rdata == 16'h0000)
      else $error("unmapped read");
   a_offset_load: assert property (
      s_off_xfer |=> reg_rdata == $past(reg_wdata, 5))
      else $error("offset not loaded");
   a_xfer_count: assert property (
      s_xfer_stat |=> reg_rdata != 16'h0000) else $error("transfer count");
   a_hold_valid: assert property (
      score_valid && !score_ready |=> score_valid) else $error("valid drop");
   a_hold_data: assert property (
      score_valid && !score_ready |=> $stable(score_out))
      else $error("score moved");
   a_ready_empty: assert property (
      !score_valid |-> samp_ready) else $error("ready while empty");
   a_full_stall: assert property (
      $fell(samp_ready) |-> $past(score_ready) == 1'b0)
      else $error("full without stall");
endmodule
bind binary_correlator corr_checker #(.DW(DW), .SCW(SCW)) u_corr_checker (
   .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .samp_a, .samp_b, .samp_valid, .samp_ready, .cascade_in, .score_out,
   .score_valid, .score_ready);

// File: sim/stream_partner.sv
// sample source and score sink beside the correlator stream
// assumes bench loads a burst count, stall stops the sink
`timescale 1ns/1ps
module stream_partner (
   input  wire       clk,
   input  wire       arst_n,
   input  wire       load,
   input  wire [7:0] load_n,
   input  wire       stall,
   output wire [7:0] samp_a,
   output wire [7:0] samp_b,
   output wire       samp_valid,
   input  wire       samp_ready,
   output wire       score_ready
);
   reg [7:0] left_q;
   reg [7:0] junk_q;
   assign samp_valid  = left_q != 8'h00;
   // idle data toggles so stale values never look valid
   assign samp_a      = samp_valid ? 8'h00 : junk_q;
   assign samp_b      = samp_a;
   assign score_ready = !stall;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         left_q <= 8'h00;
         junk_q <= 8'h5a;
      end else begin
         junk_q <= ~junk_q;
         if (load)
            left_q <= load_n;
         else if (samp_valid && samp_ready)
            left_q <= left_q - 8'h01;
      end
   end
endmodule

// File: sim/testbench.sv
// self-checking bench: host register traffic and sample stream
// assumes defs header on include path, partner in stream_partner
`timescale 1ns/1ps
`include "correlator_defs.vh"
module testbench;
   reg         clk        = 1'b0;
   reg         arst_n     = 1'b0;
   reg  [5:0]  reg_addr   = 6'h00;
   reg  [15:0] reg_wdata  = 16'h0000;
   reg         reg_wr     = 1'b0;
   reg         reg_rd     = 1'b0;
   reg  [15:0] cascade_in = 16'h0003;
   reg         load       = 1'b0;
   reg  [7:0]  load_n     = 8'h00;
   reg         stall      = 1'b0;
   reg  [15:0] exp_score  = 16'h0000;
   wire [15:0] reg_rdata, score_out;
   wire [7:0]  samp_a, samp_b;
   wire        samp_valid, samp_ready, score_valid, score_ready;
   integer     error_cnt   = 0;
   integer     comparisons = 0;
   integer     got_cnt     = 0;
   integer     k;
   always #12.5 clk = ~clk;
   binary_correlator u_binary_correlator (.clk, .arst_n, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .samp_a, .samp_b,
      .samp_valid, .samp_ready, .cascade_in, .score_out, .score_valid,
      .score_ready);
   stream_partner u_stream_partner (.clk, .arst_n, .load, .load_n, .stall,
      .samp_a, .samp_b, .samp_valid, .samp_ready, .score_ready);
   ////////////////////////////////////////////////////////////////////////
   task check(input string name, input [15:0] seen, input [15:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("wrong value %0s expected %h seen %h", name, exp, seen);
      end
   endtask
   task conclude;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wr(input [5:0] a, input [15:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task rd(input [5:0] a, input [15:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1 check("reg_rdata", reg_rdata, exp);
   endtask
   task run(input [7:0] n, input [15:0] exp);
      integer t;
      exp_score = exp;
      got_cnt   = 0;
      @(posedge clk);
      load   <= 1'b1;
      load_n <= n;
      @(posedge clk);
      load   <= 1'b0;
      for (t = 0; t < 300 && got_cnt < n; t = t + 1)
         @(posedge clk);
      check("score count", got_cnt[15:0], {8'h00, n});
   endtask
   always @(posedge clk)
      if (score_valid === 1'b1 && score_ready === 1'b1) begin
         check("score_out", score_out, exp_score);
         got_cnt = got_cnt + 1;
      end
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      for (k = 0; k < 6; k = k + 1)
         rd(k[5:0], 16'h0000);
      wr(6'h08, 16'hffff);
      rd(6'h08, 16'h0000);
      wr(`ADR_DELAY, 16'h0003);
      rd(`ADR_DELAY, 16'h0000);
      wr(`ADR_DELAY, 16'h0000);
   endtask
   task t_mask;
      for (k = 0; k < 16; k = k + 1)
         wr(`ADR_MASK0 + k[5:0], 16'hffff);
      wr(`ADR_OFFSET, 16'h0005);
      wr(`ADR_XFER, 16'h0000);
      rd(`ADR_OFFSET, 16'h0005);
      rd(`ADR_STATUS, 16'h0001);
      run(8'h02, 16'h0008);
      wr(`ADR_MASK0, 16'h0000);
      run(8'h02, 16'h0008);
      wr(`ADR_XFER, 16'h0000);
      run(8'h02, 16'h0018);
   endtask
   task t_weight;
      wr(`ADR_WEIGHT, 16'h0002);
      wr(`ADR_XFER, 16'h0000);
      rd(`ADR_STATUS, 16'h0003);
      run(8'h02, 16'h0048);
      wr(`ADR_WEIGHT, 16'h0000);
      wr(`ADR_XFER, 16'h0000);
   endtask
   task t_modes;
      for (k = 0; k < 7; k = k + 1) begin
         wr(`ADR_CTRL, k[15:0]);
         rd(`ADR_CTRL, k == 0 ? 16'h0000 : k[15:0] - 16'h0001);
         wr(`ADR_XFER, 16'h0000);
         rd(`ADR_CTRL, k[15:0]);
         run(8'h02, 16'h0018);
         rd(`ADR_SCORE_A, 16'h0015);
         rd(`ADR_SCORE_B, 16'h0005);
      end
   endtask
   task t_fifo;
      exp_score = 16'h0018;
      got_cnt   = 0;
      @(posedge clk);
      stall  <= 1'b1;
      load   <= 1'b1;
      load_n <= 8'd40;
      @(posedge clk);
      load   <= 1'b0;
      for (k = 0; k < 80 && samp_ready !== 1'b0; k = k + 1)
         @(posedge clk);
      check("samp_ready", {15'h0000, samp_ready}, 16'h0000);
      check("samp_valid", {15'h0000, samp_valid}, 16'h0001);
      stall <= 1'b0;
      for (k = 0; k < 200 && got_cnt < 40; k = k + 1)
         @(posedge clk);
      check("drained", got_cnt[15:0], 16'd40);
      #1 check("score_valid", {15'h0000, score_valid}, 16'h0000);
   endtask
   initial begin
      #500000;
      error_cnt = error_cnt + 1;
      conclude;
   end
   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      t_reset;
      t_mask;
      t_weight;
      t_modes;
      t_fifo;
      conclude;
   end
endmodule
